/* File: hw/smns_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the startup selector.
// Assumes: 100 MHz system clock.
// Notes:   Times are kept in their own unit; the hold and blink cycle counts are derived from them.
`ifndef SMNS_DEFS_SVH
`define SMNS_DEFS_SVH

`define SMNS_CLK_HZ          100000000
`define SMNS_CYC_PER_MS      (`SMNS_CLK_HZ / 1000)
`define SMNS_HALL_HOLD_MS    1000
`define SMNS_BLINK_PERIOD_MS 1000
`define SMNS_HALL_HOLD_CYC   (`SMNS_HALL_HOLD_MS * `SMNS_CYC_PER_MS)
`define SMNS_BLINK_HALF_CYC  ((`SMNS_BLINK_PERIOD_MS * `SMNS_CYC_PER_MS) / 2)
`define SMNS_SETTLE_CYC      3'h4

`define SMNS_ID_ALL_FLOAT    8'hFF
`define SMNS_NVM_PROG_ADDR   16'h4000
`define SMNS_NVM_NO_AUTORUN  16'h0001

`define SMNS_OFF_STATUS      12'h000
`define SMNS_OFF_NODE_ID     12'h004
`define SMNS_OFF_NVM_WR      12'h008
`define SMNS_OFF_SETUP       12'h00C

`define SMNS_ST_DONE         0
`define SMNS_ST_CANOPEN      1
`define SMNS_ST_UNCONF       2
`define SMNS_ST_AUTORUN      3
`define SMNS_ST_SLAVE        4
`define SMNS_ST_HALL_OVR     5
`define SMNS_ST_PROG_OK      6
`define SMNS_ST_RUNNING      7
`define SMNS_ST_STRAP_LSB    16

`define SMNS_RST_WORD        32'h0000_0000
`define SMNS_RST_NVM_DATA    16'h0000
`define SMNS_RST_NODE_ID     8'h00

`endif

/* File: hw/smns_pkg.sv */
// Purpose: Types shared by the startup selector modules.
// Assumes: Nothing beyond the defines header.
// Notes:   Strap fields are active high here: 1 means the pin is tied to ground.
package smns_pkg;

	typedef enum logic {
		SMNS_MODE_VENDOR,
		SMNS_MODE_CANOPEN
	} smns_mode_t;

	typedef enum logic [2:0] {
		SMNS_SETTLE,
		SMNS_WAIT_NVM,
		SMNS_HALL,
		SMNS_DONE
	} smns_state_t;

	typedef struct packed {
		logic       proto_on;
		logic [6:0] id_on;
	} smns_straps_t;

	typedef struct packed {
		logic        setup_valid;
		logic        id_from_sw;
		logic [7:0]  sw_node_id;
		logic [15:0] prog_word0;
		logic        prog_image_ok;
	} smns_nvm_setup_t;

	typedef struct packed {
		logic        req;
		logic [15:0] addr;
		logic [15:0] data;
	} smns_nvm_wr_t;

endpackage

/* File: hw/smns_sync.sv */
// Purpose: Two-flop synchroniser, one chain per bit.
// Assumes: Inputs are slow levels from pins.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module smns_sync #(
	parameter int          W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	if (W < 1) begin : g_bad
		$error("smns_sync: W must be at least 1.");
	end

	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_r;
		// Two stages per bit keep metastability away from the logic.
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_r <= RST_VAL[i];
				q[i]   <= RST_VAL[i];
			end else begin
				meta_r <= d[i];
				q[i]   <= meta_r;
			end
		end
	end
endmodule
`default_nettype wire

/* File: hw/smns_tick.sv */
// Purpose: Divider that gives a one-cycle enable pulse every PERIOD cycles.
// Assumes: Single clock domain.
// Notes:   The count restarts whenever en is low, so the first tick is a full period away.
`timescale 1ns/1ps
`default_nettype none
module smns_tick #(
	parameter int PERIOD = 2
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic en,
	output var  logic tick
);
	if (PERIOD < 1) begin : g_bad
		$error("smns_tick: PERIOD must be at least 1.");
	end

	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic        tick_nxt;

	// Count up to the period, then wrap and pulse.
	always_comb begin
		cnt_nxt  = cnt_r + 32'h1;
		tick_nxt = 1'b0;
		if (!en) begin
			cnt_nxt = 32'h0;
		end else if (cnt_r == 32'(PERIOD - 1)) begin
			cnt_nxt  = 32'h0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 32'h0;
			tick  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick  <= tick_nxt;
		end
	end
endmodule
`default_nettype wire

/* File: hw/smns_top.sv */
// Purpose: Power-on selection of CAN protocol mode, node identifier and auto-run for a motion drive.
// Assumes: Straps and Hall pins are pulled up on board; NVM contents arrive on nvm_setup with nvm_ready.
// Notes:   Mode, identifier and run policy are decided once after reset and then frozen until the next power-on reset.
// Function
// - A strap counts as asserted when its pin is grounded and deasserted when it floats.
// - A grounded protocol strap selects CANopen, a floating one selects the vendor CAN program mode.
// - With all seven identifier straps floating the identifier becomes 255.
// - The strap identifier is used when the stored setup picks hardware or is invalid.
// - A valid stored setup picking software supplies its own identifier from 1 to 255.
// - The strap identifier is limited to 1 to 127, or 255 when all straps float.
// - In vendor mode the drive auto-runs a valid stored program once the motor supply comes on.
// - Writing 0x0001 to the first NVM word at 0x4000 invalidates the program for later power-ups.
// - All Hall inputs held low for about one second at power-on, until green lights, force slave mode.
// - Without a valid program the drive enters slave mode whatever the Hall inputs do.
// - All straps are sampled once at power-up and the settings follow that sample.
// - CANopen mode with identifier 255 leaves the drive unconfigured, awaiting layer-setting service.
// - Unconfigured, only layer-setting service traffic is accepted or sent, boot-up included.
// - Unconfigured, the green ready indicator flashes with a one-second period.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "smns_defs.svh"
module smns_top import smns_pkg::*; #(
	parameter int HALL_HOLD_CYC  = `SMNS_HALL_HOLD_CYC,
	parameter int BLINK_HALF_CYC = `SMNS_BLINK_HALF_CYC,
	parameter int HALL_W         = 3
) (
	input  wire logic            sys_clk,
	input  wire logic            rst_b,
	input  wire logic            proto_strap_n,
	input  wire logic [6:0]      node_id_strap_bit_n,
	input  wire logic [HALL_W-1:0] hall_in,
	input  wire logic            motor_supply_on,
	input  wire logic            nvm_ready,
	input  wire smns_nvm_setup_t nvm_setup,
	input  wire logic            can_rx_valid,
	input  wire logic            can_rx_lss,
	input  wire logic            can_tx_req,
	input  wire logic            can_tx_lss,
	input  wire logic [11:0]     paddr,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [31:0]     pwdata,
	input  wire logic [3:0]      pstrb,
	output var  logic [31:0]     prdata,
	output var  logic            pready,
	output var  logic            pslverr,
	output var  smns_mode_t      proto_mode,
	output var  logic [7:0]      node_identifier,
	output var  logic            config_done,
	output var  logic            unconfigured,
	output var  logic            autorun_armed,
	output var  logic            slave_mode,
	output var  logic            program_start,
	output var  logic            program_run,
	output var  logic            led_ready,
	output var  logic            can_rx_accept,
	output var  logic            can_tx_grant,
	output var  smns_nvm_wr_t    nvm_wr
);
	if (HALL_HOLD_CYC < 1 || BLINK_HALF_CYC < 1 || HALL_W < 1) begin : g_bad
		$error("smns_top: counts and widths must be at least 1.");
	end

	localparam int SW = 9 + HALL_W;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisation.

	logic rst_meta_r;
	logic rst_n;

	// Reset asserts at once but releases on the clock, so no flop sees a runt release.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	logic [SW-1:0]     pins_s;
	logic              s_proto_n;
	logic [6:0]        s_id_n;
	logic [HALL_W-1:0] s_hall;
	logic              s_motor;

	smns_sync #(
		.W       (SW),
		.RST_VAL ({1'b0, {HALL_W{1'b1}}, 8'hFF})
	) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.d       ({motor_supply_on, hall_in, node_id_strap_bit_n, proto_strap_n}),
		.q       (pins_s)
	);

	assign {s_motor, s_hall, s_id_n, s_proto_n} = pins_s;

	////////////////////////////////////////////////////////////////////////////////
	// Power-up sequence: settle, capture, Hall hold window.

	smns_state_t     state_r,    state_nxt;
	logic [2:0]      settle_r,   settle_nxt;
	logic [31:0]     hold_r,     hold_nxt;
	logic            hall_ok_r,  hall_ok_nxt;
	logic            hall_ovr_r, hall_ovr_nxt;
	smns_straps_t    straps_r,   straps_nxt;
	smns_nvm_setup_t setup_r,    setup_nxt;
	logic            hall_all_low;

	assign hall_all_low = (s_hall == '0);

	// Straps are read once, after the synchronisers have filled; later changes are never looked at.
	always_comb begin
		state_nxt    = state_r;
		settle_nxt   = settle_r;
		hold_nxt     = hold_r;
		hall_ok_nxt  = hall_ok_r;
		hall_ovr_nxt = hall_ovr_r;
		straps_nxt   = straps_r;
		setup_nxt    = setup_r;
		case (state_r)
			SMNS_SETTLE: begin
				if (settle_r == `SMNS_SETTLE_CYC - 3'h1) begin
					state_nxt = SMNS_WAIT_NVM;
				end else begin
					settle_nxt = settle_r + 3'h1;
				end
			end
			SMNS_WAIT_NVM: begin
				if (nvm_ready) begin
					straps_nxt.proto_on = ~s_proto_n;
					straps_nxt.id_on    = ~s_id_n;
					setup_nxt           = nvm_setup;
					hold_nxt            = 32'h0;
					hall_ok_nxt         = hall_all_low;
					state_nxt           = SMNS_HALL;
				end
			end
			SMNS_HALL: begin
				hall_ok_nxt = hall_ok_r & hall_all_low;
				if (hold_r == 32'(HALL_HOLD_CYC - 1)) begin
					hall_ovr_nxt = hall_ok_r & hall_all_low;
					state_nxt    = SMNS_DONE;
				end else begin
					hold_nxt = hold_r + 32'h1;
				end
			end
			SMNS_DONE: begin
				state_nxt = SMNS_DONE;
			end
			default: begin
				state_nxt = SMNS_SETTLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= SMNS_SETTLE;
			settle_r   <= 3'h0;
			hold_r     <= 32'h0;
			hall_ok_r  <= 1'b0;
			hall_ovr_r <= 1'b0;
			straps_r   <= '0;
			setup_r    <= '0;
		end else begin
			state_r    <= state_nxt;
			settle_r   <= settle_nxt;
			hold_r     <= hold_nxt;
			hall_ok_r  <= hall_ok_nxt;
			hall_ovr_r <= hall_ovr_nxt;
			straps_r   <= straps_nxt;
			setup_r    <= setup_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Resolution of mode, identifier and run policy from the captured values.

	logic       done;
	logic [7:0] hw_id;
	logic [7:0] id_res;
	logic       use_hw;
	logic       prog_ok;
	logic       autorun;

	assign done    = (state_r == SMNS_DONE);
	assign hw_id   = (straps_r.id_on == 7'h00) ? `SMNS_ID_ALL_FLOAT
	                                           : {1'b0, straps_r.id_on};
	// A stored software identifier of zero is outside 1..255, so it is treated as an invalid setup.
	assign use_hw  = !setup_r.setup_valid || !setup_r.id_from_sw
	               || (setup_r.sw_node_id == 8'h00);
	assign id_res  = use_hw ? hw_id : setup_r.sw_node_id;
	assign prog_ok = setup_r.prog_image_ok
	               && (setup_r.prog_word0 != `SMNS_NVM_NO_AUTORUN);
	assign autorun = straps_r.proto_on ? 1'b0
	               : (prog_ok && !hall_ovr_r);

	smns_mode_t mode_nxt;
	logic [7:0] id_nxt;
	logic       unconf_nxt;
	logic       arm_nxt;
	logic       slave_nxt;
	logic       start_nxt;
	logic       run_nxt;

	// Outputs are loaded once the sequence ends and hold afterwards, except program_start and program_run, which wait for the motor supply.
	always_comb begin
		mode_nxt   = proto_mode;
		id_nxt     = node_identifier;
		unconf_nxt = unconfigured;
		arm_nxt    = autorun_armed;
		slave_nxt  = slave_mode;
		run_nxt    = program_run;
		start_nxt  = 1'b0;
		if (done) begin
			mode_nxt   = straps_r.proto_on ? SMNS_MODE_CANOPEN : SMNS_MODE_VENDOR;
			id_nxt     = id_res;
			unconf_nxt = straps_r.proto_on && (id_res == `SMNS_ID_ALL_FLOAT);
			arm_nxt    = autorun;
			slave_nxt  = !autorun;
			if (autorun && s_motor && !program_run) begin
				start_nxt = 1'b1;
				run_nxt   = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			proto_mode      <= SMNS_MODE_VENDOR;
			node_identifier <= `SMNS_RST_NODE_ID;
			config_done     <= 1'b0;
			unconfigured    <= 1'b0;
			autorun_armed   <= 1'b0;
			slave_mode      <= 1'b0;
			program_start   <= 1'b0;
			program_run     <= 1'b0;
		end else begin
			proto_mode      <= mode_nxt;
			node_identifier <= id_nxt;
			config_done     <= done;
			unconfigured    <= unconf_nxt;
			autorun_armed   <= arm_nxt;
			slave_mode      <= slave_nxt;
			program_start   <= start_nxt;
			program_run     <= run_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Ready indicator and CAN traffic gate.

	logic blink_tick;

	smns_tick #(
		.PERIOD (BLINK_HALF_CYC)
	) u_blink (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.en      (unconfigured),
		.tick    (blink_tick)
	);

	logic led_nxt;
	logic rx_nxt;
	logic tx_nxt;

	// Until the sequence ends nothing passes; unconfigured, only layer-setting frames do.
	always_comb begin
		led_nxt = config_done;
		if (unconfigured) begin
			led_nxt = blink_tick ? !led_ready : led_ready;
		end
		rx_nxt = can_rx_valid && config_done && (!unconfigured || can_rx_lss);
		tx_nxt = can_tx_req && config_done && (!unconfigured || can_tx_lss);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			led_ready     <= 1'b0;
			can_rx_accept <= 1'b0;
			can_tx_grant  <= 1'b0;
		end else begin
			led_ready     <= led_nxt;
			can_rx_accept <= rx_nxt;
			can_tx_grant  <= tx_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, pready is a registered one-cycle pulse.

	logic        access;
	logic        commit_wr;
	logic        mapped;
	logic [31:0] rd;
	logic [15:0] wdata_r, wdata_nxt;
	logic [31:0] prdata_nxt;
	logic        pready_nxt;
	logic        pslverr_nxt;
	smns_nvm_wr_t nvm_wr_nxt;

	assign access    = psel && penable;
	assign commit_wr = access && pready && pwrite && (paddr == `SMNS_OFF_NVM_WR);

	// Read decode; misaligned and unknown offsets are unmapped and answer with an error.
	always_comb begin
		rd     = `SMNS_RST_WORD;
		mapped = 1'b0;
		case (paddr)
			`SMNS_OFF_STATUS: begin
				mapped                  = 1'b1;
				rd[`SMNS_ST_DONE]       = config_done;
				rd[`SMNS_ST_CANOPEN]    = (proto_mode == SMNS_MODE_CANOPEN);
				rd[`SMNS_ST_UNCONF]     = unconfigured;
				rd[`SMNS_ST_AUTORUN]    = autorun_armed;
				rd[`SMNS_ST_SLAVE]      = slave_mode;
				rd[`SMNS_ST_HALL_OVR]   = hall_ovr_r;
				rd[`SMNS_ST_PROG_OK]    = prog_ok;
				rd[`SMNS_ST_RUNNING]    = program_run;
				rd[`SMNS_ST_STRAP_LSB +: 8] = straps_r;
			end
			`SMNS_OFF_NODE_ID: begin
				mapped = 1'b1;
				rd     = {16'h0000, hw_id, node_identifier};
			end
			`SMNS_OFF_NVM_WR: begin
				mapped = 1'b1;
				rd     = {16'h0000, wdata_r};
			end
			`SMNS_OFF_SETUP: begin
				mapped = 1'b1;
				rd     = {5'h00, setup_r};
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// A write to the NVM word register becomes a one-cycle write request to the first program word.
	always_comb begin
		pready_nxt  = access && !pready;
		pslverr_nxt = access && !pready && !mapped;
		prdata_nxt  = (access && !pready && !pwrite) ? rd : `SMNS_RST_WORD;
		wdata_nxt   = wdata_r;
		if (commit_wr && pstrb[0]) begin
			wdata_nxt[7:0] = pwdata[7:0];
		end
		if (commit_wr && pstrb[1]) begin
			wdata_nxt[15:8] = pwdata[15:8];
		end
		nvm_wr_nxt.req  = commit_wr && (pstrb[1:0] != 2'b00);
		nvm_wr_nxt.addr = `SMNS_NVM_PROG_ADDR;
		nvm_wr_nxt.data = wdata_nxt;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= `SMNS_RST_WORD;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			wdata_r <= `SMNS_RST_NVM_DATA;
			nvm_wr  <= '0;
		end else begin
			prdata  <= prdata_nxt;
			pready  <= pready_nxt;
			pslverr <= pslverr_nxt;
			wdata_r <= wdata_nxt;
			nvm_wr  <= nvm_wr_nxt;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/smns_checker.sv */
// Purpose: Concurrent checks on the startup selector ports.
// Assumes: Bound into smns_top; blink count shortened in simulation.
// Notes:   All outputs are zero in reset, so reset disables every check.
`timescale 1ns/1ps
`default_nettype none
module smns_checker import smns_pkg::*; #(
	parameter int BLINK_HALF_CYC = 4
) (
	input wire logic         sys_clk,
	input wire logic         rst_b,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic [11:0]  paddr,
	input wire logic         pready,
	input wire logic         pslverr,
	input wire logic [31:0]  prdata,
	input wire smns_mode_t   proto_mode,
	input wire logic [7:0]   node_identifier,
	input wire logic         config_done,
	input wire logic         unconfigured,
	input wire logic         autorun_armed,
	input wire logic         slave_mode,
	input wire logic         program_start,
	input wire logic         program_run,
	input wire logic         led_ready,
	input wire logic         can_rx_valid,
	input wire logic         can_rx_lss,
	input wire logic         can_rx_accept,
	input wire smns_nvm_wr_t nvm_wr
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	int unsigned led_cnt_r;
	int unsigned led_cnt_nxt;
	logic        led_prev_r;
	////////////////////////////////////////
	// Cycles the indicator has held its level while unconfigured; a stuck indicator lets it grow.
	always_comb begin
		led_cnt_nxt = (led_ready != led_prev_r || !unconfigured) ? 0 : led_cnt_r + 1;
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			led_cnt_r <= 0;
			led_prev_r <= 1'b0;
		end else begin
			led_cnt_r <= led_cnt_nxt;
			led_prev_r <= led_ready;
		end
	end
	// The access phase waits exactly one cycle, then the answer drops.
	sequence s_access_wait;
		psel && penable && !pready;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	chk_apb_one_wait: assert property (s_access_wait |=> s_answer)
		else $error("APB wait state wrong");
	chk_apb_refuse: assert property (pready && (paddr > 12'h00C || paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0)
		else $error("Unmapped access accepted");
	chk_unconf_def: assert property (config_done |-> unconfigured == (proto_mode == SMNS_MODE_CANOPEN && node_identifier == 8'hFF))
		else $error("Unconfigured flag wrong");
	chk_lss_block: assert property (can_rx_valid && !can_rx_lss && unconfigured |=> !can_rx_accept)
		else $error("Non-LSS frame accepted");
	chk_lss_pass: assert property (config_done && can_rx_valid && can_rx_lss |=> can_rx_accept)
		else $error("LSS frame refused");
	chk_frozen_cfg: assert property (config_done |=> config_done && $stable(node_identifier) && $stable(proto_mode))
		else $error("Settings moved");
	chk_led_blink: assert property (unconfigured && led_ready == led_prev_r |-> led_cnt_r <= BLINK_HALF_CYC)
		else $error("Indicator not flashing");
	chk_start_once: assert property (program_start |-> autorun_armed ##1 (program_run && !program_start))
		else $error("Bad program start");
	chk_slave_split: assert property (config_done |-> slave_mode == !autorun_armed && (proto_mode == SMNS_MODE_VENDOR || slave_mode))
		else $error("Slave and auto-run clash");
	chk_quiet_early: assert property (!config_done |-> node_identifier == 8'h00 && !autorun_armed && !program_start)
		else $error("Outputs set early");
	chk_nvm_req: assert property (nvm_wr.req |-> nvm_wr.addr == 16'h4000 && $past(pready) ##1 !nvm_wr.req)
		else $error("Bad memory write");
endmodule
bind smns_top smns_checker #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) smns_checker_inst (.sys_clk, .rst_b, .psel,
	.penable, .paddr, .pready, .pslverr, .prdata, .proto_mode, .node_identifier, .config_done, .unconfigured,
	.autorun_armed, .slave_mode, .program_start, .program_run, .led_ready, .can_rx_valid, .can_rx_lss,
	.can_rx_accept, .nvm_wr);
`default_nettype wire

/* File: testbench/smns_board_model.sv */
// Purpose: Board side of the selector: pulled-up straps and setup memory.
// Assumes: Straps are given active high; a floating pin reads high.
// Notes:   Memory answers after ready_dly cycles, shows inverted data before.
`timescale 1ns/1ps
`default_nettype none
module smns_board_model import smns_pkg::*; (
	input  wire logic            sys_clk,
	input  wire logic            rst_b,
	input  wire smns_straps_t    straps,
	input  wire smns_nvm_setup_t img,
	input  wire logic            nvm_load,
	input  wire logic [3:0]      ready_dly,
	input  wire smns_nvm_wr_t    nvm_wr,
	output var  logic            proto_strap_n,
	output var  logic [6:0]      node_id_strap_bit_n,
	output var  logic            nvm_ready,
	output var  smns_nvm_setup_t nvm_setup
);
	logic [15:0]     word0_r;
	logic [3:0]      wait_r;
	smns_nvm_setup_t stored;
	////////////////////////////////////////
	// Pull-ups make a floating pin high; a grounded strap reads low.
	assign proto_strap_n = ~straps.proto_on;
	assign node_id_strap_bit_n = ~straps.id_on;
	// Before the memory is ready its lines carry junk, never the image.
	always_comb begin
		stored = img;
		stored.prog_word0 = word0_r;
	end
	assign nvm_ready = (wait_r == ready_dly);
	assign nvm_setup = nvm_ready ? stored : ~stored;
	// Word zero is preloaded by the bench and rewritten by the drive.
	always_ff @(posedge sys_clk) begin
		if (nvm_load) begin
			word0_r <= img.prog_word0;
		end else if (nvm_wr.req && nvm_wr.addr == 16'h4000) begin
			word0_r <= nvm_wr.data;
		end
	end
	// Read latency counts from reset release, then the answer holds.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_r <= 4'h0;
		end else if (wait_r != ready_dly) begin
			wait_r <= wait_r + 4'h1;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the startup selector.
// Assumes: Hold window 20 cycles, half blink 4 cycles.
// Notes:   Each scenario powers the block up afresh.
`timescale 1ns/1ps
`default_nettype none
module tb import smns_pkg::*;;
	localparam smns_nvm_setup_t GOOD = '{1'b1, 1'b0, 8'h00, 16'h1234, 1'b1};
	logic            sys_clk = 1'b0;
	logic            rst_b = 1'b0;
	logic [2:0]      hall_in = 3'h7;
	logic            motor_supply_on = 1'b0;
	logic            can_rx_valid = 1'b0, can_rx_lss = 1'b0, can_tx_req = 1'b0, can_tx_lss = 1'b0;
	logic [11:0]     paddr = 12'h000;
	logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0]     pwdata = 32'h0, prdata;
	logic            pready, pslverr, config_done, unconfigured, autorun_armed, slave_mode;
	logic            program_start, program_run, led_ready, can_rx_accept, can_tx_grant;
	logic            proto_strap_n, nvm_ready, nvm_load = 1'b0;
	logic [6:0]      node_id_strap_bit_n;
	logic [7:0]      node_identifier;
	logic [3:0]      ready_dly = 4'h0;
	smns_mode_t      proto_mode;
	smns_nvm_wr_t    nvm_wr;
	smns_nvm_setup_t nvm_setup, img = '0;
	smns_straps_t    straps = '0;
	int              fails = 0, cmp_count = 0;
	////////////////////////////////////////
	// The byte strobes stay full; the write path is exercised at full width.
	smns_top #(.HALL_HOLD_CYC(20), .BLINK_HALF_CYC(4), .HALL_W(3)) smns_top_inst (.sys_clk, .rst_b,
		.proto_strap_n, .node_id_strap_bit_n, .hall_in, .motor_supply_on, .nvm_ready, .nvm_setup, .can_rx_valid,
		.can_rx_lss, .can_tx_req, .can_tx_lss, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF), .prdata,
		.pready, .pslverr, .proto_mode, .node_identifier, .config_done, .unconfigured, .autorun_armed,
		.slave_mode, .program_start, .program_run, .led_ready, .can_rx_accept, .can_tx_grant, .nvm_wr);
	smns_board_model smns_board_model_inst (.sys_clk, .rst_b, .straps, .img, .nvm_load, .ready_dly, .nvm_wr,
		.proto_strap_n, .node_id_strap_bit_n, .nvm_ready, .nvm_setup);
	// Free-running 100 MHz clock.
	always #5 sys_clk = ~sys_clk;
	task automatic tally_and_finish;
		if (fails == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			fails++;
			$display("Error at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Power cycle with given straps and memory; Halls grounded for hold cycles.
	task automatic power_up(input smns_straps_t s, input smns_nvm_setup_t im, input logic ld, input int hold,
		input logic [3:0] dly);
		int n;
		straps <= s;
		img <= im;
		nvm_load <= ld;
		ready_dly <= dly;
		hall_in <= (hold > 0) ? 3'h0 : 3'h7;
		motor_supply_on <= 1'b0;
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		nvm_load <= 1'b0;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (n == hold) hall_in <= 3'h7;
		end while (config_done !== 1'b1);
		check(32'(config_done), 32'h1);
		@(posedge sys_clk);
	endtask
	// One frame on the receive or transmit path, judged one cycle later.
	task automatic can_step(input logic rx, input logic lss, input logic want);
		can_rx_valid <= rx;
		can_tx_req <= !rx;
		can_rx_lss <= lss;
		can_tx_lss <= lss;
		@(posedge sys_clk);
		can_rx_valid <= 1'b0;
		can_tx_req <= 1'b0;
		@(posedge sys_clk);
		check(32'(rx ? can_rx_accept : can_tx_grant), 32'(want));
	endtask
	task automatic t_vendor_autorun;
		logic [31:0] rd;
		logic        err;
		power_up('{1'b0, 7'h05}, GOOD, 1'b1, 0, 4'h0);
		check(32'(proto_mode), 32'(SMNS_MODE_VENDOR));
		check(32'(node_identifier), 32'h05);
		check(32'(autorun_armed), 32'h1);
		can_step(1'b1, 1'b0, 1'b1);
		motor_supply_on <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (program_start !== 1'b1);
		check(32'(program_start), 32'h1);
		apb(1'b0, 12'h000, 32'h0, rd, err);
		check(rd, 32'h0005_00C9);
		// An unmapped offset is refused with an error and no data.
		apb(1'b0, 12'h010, 32'h0, rd, err);
		check(rd, 32'h0);
		check(32'(err), 32'h1);
	endtask
	task automatic t_invalidate;
		logic [31:0] rd;
		logic        err;
		apb(1'b1, 12'h008, 32'h0000_0001, rd, err);
		check(32'(err), 32'h0);
		apb(1'b0, 12'h008, 32'h0, rd, err);
		check(rd, 32'h0000_0001);
		power_up('{1'b0, 7'h05}, GOOD, 1'b0, 0, 4'hC);
		check(32'(slave_mode), 32'h1);
	endtask
	task automatic t_hall;
		int hold [2] = '{100, 15};
		for (int i = 0; i < 2; i++) begin
			power_up('{1'b0, 7'h05}, GOOD, 1'b1, hold[i], 4'h0);
			check(32'(slave_mode), 32'(i == 0));
		end
	endtask
	task automatic t_unconfigured;
		int   tg;
		logic p;
		power_up('{1'b1, 7'h00}, '{1'b0, 1'b0, 8'h00, 16'h1234, 1'b1}, 1'b1, 0, 4'h3);
		check(32'(node_identifier), 32'hFF);
		check(32'(proto_mode), 32'(SMNS_MODE_CANOPEN));
		check(32'(unconfigured), 32'h1);
		repeat (8) @(posedge sys_clk);
		tg = 0;
		p = led_ready;
		repeat (20) begin
			@(posedge sys_clk);
			if (led_ready !== p) tg++;
			p = led_ready;
		end
		check(32'(tg), 32'd5);
		can_step(1'b1, 1'b0, 1'b0);
		can_step(1'b1, 1'b1, 1'b1);
		can_step(1'b0, 1'b0, 1'b0);
		can_step(1'b0, 1'b1, 1'b1);
	endtask
	task automatic t_id_table;
		logic [7:0] sid [4] = '{8'h10, 8'hC8, 8'hC8, 8'hFF};
		logic [6:0] pin [4] = '{7'h7F, 7'h03, 7'h03, 7'h01};
		logic       val [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
		logic [7:0] want [4] = '{8'h7F, 8'hC8, 8'h03, 8'hFF};
		for (int i = 0; i < 4; i++) begin
			power_up('{1'b0, pin[i]}, '{val[i], i > 0, sid[i], 16'h1234, 1'b1}, 1'b1, 0, 4'h1);
			check(32'(node_identifier), 32'(want[i]));
		end
		straps <= '{1'b1, 7'h22};
		repeat (4) @(posedge sys_clk);
		check(32'(node_identifier), 32'hFF);
		check(32'(proto_mode), 32'(SMNS_MODE_VENDOR));
	endtask
	// Main sequence.
	initial begin
		t_vendor_autorun;
		t_invalidate;
		t_hall;
		t_unconfigured;
		t_id_table;
		tally_and_finish;
	end
	// Watchdog well beyond the few hundred cycles the scenarios need.
	initial begin
		repeat (5000) @(posedge sys_clk);
		fails++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
